/* common/epwm_pkg.sv */
/*
 * Shared constants of the two eleven-bit PWM generators: register indices,
 * field positions, reset values, pin routing codes and prescaler limits.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package epwm_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam int NUM_GEN = 2;
    localparam logic [5:0] IDX_CTRL [NUM_GEN] = '{6'h20, 6'h26};
    localparam logic [5:0] IDX_SCALER [NUM_GEN] = '{6'h21, 6'h27};
    localparam logic [5:0] IDX_DUTY_HIGH [NUM_GEN] = '{6'h22, 6'h28};
    localparam logic [5:0] IDX_DUTY_LOW [NUM_GEN] = '{6'h23, 6'h29};
    localparam logic [5:0] IDX_BOUND_HIGH [NUM_GEN] = '{6'h24, 6'h2A};
    localparam logic [5:0] IDX_BOUND_LOW [NUM_GEN] = '{6'h25, 6'h2B};

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_INV_BIT = 5;
    localparam int CTRL_CLR_BIT = 4;
    localparam int CTRL_PIN_LSB = 1;
    localparam int CTRL_PIN_MSB = 3;
    localparam int CTRL_SRC_BIT = 0;

    // ************************************************************
    // Scaler, bound and duty fields
    // ************************************************************
    localparam int SCL_INT_BIT = 7;
    localparam int SCL_PRE_LSB = 5;
    localparam int SCL_PRE_MSB = 6;
    localparam int SCL_DIV_MSB = 4;
    localparam int BND_LOW_LSB = 6;
    localparam int DTY_LOW_LSB = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SCL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [10:0] WORD11_RST = 11'h000;

    // ************************************************************
    // Output pin codes and prescaler terminal counts
    // ************************************************************
    localparam logic [2:0] PIN_CODE [3] = '{3'h1, 3'h3, 3'h4};
    localparam int PINS_PER_GEN = 3;
    localparam logic [5:0] PRE_LIM_DIV1 = 6'h00;
    localparam logic [5:0] PRE_LIM_DIV4 = 6'h03;
    localparam logic [5:0] PRE_LIM_DIV16 = 6'h0F;
    localparam logic [5:0] PRE_LIM_DIV64 = 6'h3F;

    // Prescaler choice
    typedef enum logic [1:0] {
        PRE_DIV1, PRE_DIV4, PRE_DIV16, PRE_DIV64
    } epwm_pre_t;

endpackage

/* hw/epwm_fast_tick.sv */
/*
 * Turns the fast RC oscillator level into a one-cycle tick per rising edge.
 * Assumes the oscillator input is already synchronous to ref_clk and
 * slower than half of ref_clk.
 */
`timescale 1ns/1ps
module epwm_fast_tick (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Oscillator level in, tick out
    input wire logic fastRcLevel,
    output logic fastTick
);
    logic prevLevel_r; // Level seen one cycle earlier

    // ************************************************************
    // Edge detector
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevLevel_r <= 1'b0;
        end else if (clkEn) begin
            prevLevel_r <= fastRcLevel;
        end
    end

    // Rising edge only; gated by enable so frozen time makes no tick
    assign fastTick = clkEn & fastRcLevel & ~prevLevel_r;
endmodule // epwm_fast_tick

/* hw/epwm_gen.sv */
/*
 * One eleven-bit PWM generator: prescaler, 5-bit divider, up counter with
 * bound, duty compare, polarity and interrupt pulse.
 * Assumes settings are held stable by the register block.
 */
`timescale 1ns/1ps
module epwm_gen
    import epwm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Settings
    input wire logic enable,
    input wire logic invert,
    input wire logic srcFast,
    input wire logic fastTick,
    input wire logic [1:0] preSel,
    input wire logic [4:0] divider,
    input wire logic intAtZero,
    input wire logic [10:0] bound,
    input wire logic [10:0] duty,
    input wire logic clearReq,
    // Results
    output logic outLevel,
    output logic irqPulse,
    output logic clearDone
);
    logic [5:0] preCnt_r; // Prescaler count
    logic [4:0] divCnt_r; // Divider count
    logic [10:0] cnt_r; // Main counter
    logic [10:0] cnt_nxt; // Counter after a tick
    logic [5:0] preLim; // Prescaler terminal count
    logic srcTick; // Selected source tick
    logic preHit; // Prescaler terminal reached
    logic divHit; // Divided tick

    // Prescaler limit decode
    always_comb begin
        case (epwm_pre_t'(preSel))
            PRE_DIV1: preLim = PRE_LIM_DIV1;
            PRE_DIV4: preLim = PRE_LIM_DIV4;
            PRE_DIV16: preLim = PRE_LIM_DIV16;
            PRE_DIV64: preLim = PRE_LIM_DIV64;
            default: preLim = PRE_LIM_DIV1;
        endcase
    end

    assign srcTick = srcFast ? fastTick : 1'b1;
    // Prescale then divide
    // Compare is at-or-above so a smaller new setting cannot strand a count
    assign preHit = srcTick & (preCnt_r >= preLim);
    assign divHit = preHit & (divCnt_r >= divider);
    assign cnt_nxt = (cnt_r >= bound) ? WORD11_RST : cnt_r + 11'h001;

    // ************************************************************
    // Prescaler and divider
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_r <= 6'h00;
            divCnt_r <= 5'h00;
        end else if (clkEn) begin
            if (clearReq || !enable) begin
                preCnt_r <= 6'h00;
                divCnt_r <= 5'h00;
            end else if (srcTick) begin
                preCnt_r <= preHit ? 6'h00 : preCnt_r + 6'h01;
                if (preHit) begin
                    divCnt_r <= divHit ? 5'h00 : divCnt_r + 5'h01;
                end
            end
        end
    end

    // ************************************************************
    // Counter, output and interrupt
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= WORD11_RST;
            outLevel <= 1'b0;
            irqPulse <= 1'b0;
            clearDone <= 1'b0;
        end else if (clkEn) begin
            if (clearReq) begin
                cnt_r <= WORD11_RST;
            end else if (enable && divHit) begin
                cnt_r <= cnt_nxt;
            end
            outLevel <= (enable & (cnt_r < duty)) ^ invert;
            irqPulse <= enable & divHit & ~clearReq &
                        (intAtZero ? (cnt_nxt == WORD11_RST) : (cnt_nxt == duty));
            clearDone <= clearReq;
        end
    end
endmodule // epwm_gen

/* hw/epwm_top.sv */
/*
 * Register block and pin routing for two eleven-bit PWM generators behind
 * an APB slave. Each register is one aligned word; byte address is four
 * times the register index.
 * Assumes APB signals and the fast RC level are synchronous to ref_clk.
 */
// Our own choice: register access over APB.
`timescale 1ns/1ps

// What this block does
// - Generator A runs only when enabled
// - A control bit 6 reads output
// - A polarity inversion bit
// - Writing 1 clears A counter
// - A output pin routing codes
// - A clock source choice
// - Interrupt at duty match or zero
// - Prescaler then 5-bit divider
// - Bound from high and low registers
// - Duty from high and low registers
// - Generator B enable, output readback
// - B polarity inversion bit
// - B clear bit self clears
// - B output pin routing codes
// - B clock source choice
module epwm_top
    import epwm_pkg::*;
(
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fast RC oscillator level
    input wire logic internalFastRcClock,
    // Generator A pins
    output logic portBPin5Out,
    output logic portBPin5Oe,
    output logic portAPin0Out,
    output logic portAPin0Oe,
    output logic portBPin4Out,
    output logic portBPin4Oe,
    // Generator B pins
    output logic portBPin6Out,
    output logic portBPin6Oe,
    output logic portAPin4Out,
    output logic portAPin4Oe,
    output logic portBPin7Out,
    output logic portBPin7Oe,
    // Interrupt request pulses
    output logic pwmGenAIrq,
    output logic pwmGenBIrq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int NUM_PINS = NUM_GEN * PINS_PER_GEN;

    logic [5:0] regIdx; // Word index of the access
    logic accessPhase; // Access phase, not yet answered
    logic commit; // Edge at which the access completes
    logic wrCommit; // Write takes effect
    logic [NUM_GEN-1:0] hitGen; // Address hits a generator
    logic addrValid; // Address is mapped
    logic [7:0] readByte; // Read data before the flop
    logic fastTick; // Rising edge of fast RC

    logic [7:0] ctrl_r [NUM_GEN]; // Control registers
    logic [7:0] scaler_r [NUM_GEN]; // Scaler registers
    logic [2:0] dutyLow_r [NUM_GEN]; // Pending duty low bits
    logic [10:0] duty_r [NUM_GEN]; // Applied duty value
    logic [7:0] boundHigh_r [NUM_GEN]; // Bound bits 10 to 3
    logic [1:0] boundLow_r [NUM_GEN]; // Bound bits 2 to 1
    logic [NUM_GEN-1:0] genOut; // Generator outputs
    logic [NUM_GEN-1:0] genIrq; // Generator interrupt pulses
    logic [NUM_GEN-1:0] genClrDone; // Clear finished

    logic [NUM_PINS-1:0] pinOut_r; // Pin levels
    logic [NUM_PINS-1:0] pinOe_r; // Pin drive enables
    logic [NUM_GEN-1:0] irq_r; // Registered interrupt pulses

    // ************************************************************
    // APB decode
    // ************************************************************
    assign regIdx = paddr[7:2];
    // First access cycle is used to form the read data
    assign accessPhase = psel & penable & ~pready;
    // Second access cycle is the one with pready high
    assign commit = psel & penable & pready;
    assign wrCommit = commit & pwrite;
    assign addrValid = |hitGen;

    // Fast RC edge to tick
    epwm_fast_tick u_fast_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .fastRcLevel(internalFastRcClock),
        .fastTick(fastTick)
    );

    // ************************************************************
    // Per-generator registers and core
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g++) begin : gen_pwm
            logic wrCtrl; // Control write
            logic wrScaler; // Scaler write
            logic wrDutyHigh; // Duty high write
            logic wrDutyLow; // Duty low write
            logic wrBoundHigh; // Bound high write
            logic wrBoundLow; // Bound low write
            logic [10:0] boundFull; // Full bound value

            assign hitGen[g] = (regIdx == IDX_CTRL[g]) || (regIdx == IDX_SCALER[g]) ||
                               (regIdx == IDX_DUTY_HIGH[g]) || (regIdx == IDX_DUTY_LOW[g]) ||
                               (regIdx == IDX_BOUND_HIGH[g]) || (regIdx == IDX_BOUND_LOW[g]);
            assign wrCtrl = wrCommit & (regIdx == IDX_CTRL[g]);
            assign wrScaler = wrCommit & (regIdx == IDX_SCALER[g]);
            assign wrDutyHigh = wrCommit & (regIdx == IDX_DUTY_HIGH[g]);
            assign wrDutyLow = wrCommit & (regIdx == IDX_DUTY_LOW[g]);
            assign wrBoundHigh = wrCommit & (regIdx == IDX_BOUND_HIGH[g]);
            assign wrBoundLow = wrCommit & (regIdx == IDX_BOUND_LOW[g]);

            // Bound assembled, bit 0 forced low
            assign boundFull = {boundHigh_r[g], boundLow_r[g], 1'b0};

            // Control register; bit 6 is not stored, it reads the output
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_r[g] <= CTRL_RST;
                end else if (clkEn) begin
                    if (wrCtrl) begin
                        ctrl_r[g][CTRL_EN_BIT] <= pwdata[CTRL_EN_BIT];
                        ctrl_r[g][CTRL_INV_BIT] <= pwdata[CTRL_INV_BIT];
                        ctrl_r[g][CTRL_PIN_MSB:CTRL_PIN_LSB] <= pwdata[CTRL_PIN_MSB:CTRL_PIN_LSB];
                        ctrl_r[g][CTRL_SRC_BIT] <= pwdata[CTRL_SRC_BIT];
                    end
                    // Write 1 sets; a new set beats the self clear
                    if (wrCtrl && pwdata[CTRL_CLR_BIT]) begin
                        ctrl_r[g][CTRL_CLR_BIT] <= 1'b1;
                    end else if (genClrDone[g]) begin
                        ctrl_r[g][CTRL_CLR_BIT] <= 1'b0;
                    end
                end
            end

            // Scaler register, write only
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    scaler_r[g] <= SCL_RST;
                end else if (clkEn && wrScaler) begin
                    scaler_r[g] <= pwdata[7:0];
                end
            end

            // Duty low waits; high write applies both
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dutyLow_r[g] <= 3'h0;
                    duty_r[g] <= WORD11_RST;
                end else if (clkEn) begin
                    if (wrDutyLow) begin
                        dutyLow_r[g] <= pwdata[7:DTY_LOW_LSB];
                    end
                    // Low must already be written by software
                    if (wrDutyHigh) begin
                        duty_r[g] <= {pwdata[7:0], dutyLow_r[g]};
                    end
                end
            end

            // Bound registers take effect at once
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    boundHigh_r[g] <= BYTE_RST;
                    boundLow_r[g] <= 2'h0;
                end else if (clkEn) begin
                    if (wrBoundHigh) begin
                        boundHigh_r[g] <= pwdata[7:0];
                    end
                    if (wrBoundLow) begin
                        boundLow_r[g] <= pwdata[7:BND_LOW_LSB];
                    end
                end
            end

            // Core runs on the enable bit
            epwm_gen u_gen (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .clkEn(clkEn),
                .enable(ctrl_r[g][CTRL_EN_BIT]),
                .invert(ctrl_r[g][CTRL_INV_BIT]),
                .srcFast(ctrl_r[g][CTRL_SRC_BIT]),
                .fastTick(fastTick),
                .preSel(scaler_r[g][SCL_PRE_MSB:SCL_PRE_LSB]),
                .divider(scaler_r[g][SCL_DIV_MSB:0]),
                .intAtZero(scaler_r[g][SCL_INT_BIT]),
                .bound(boundFull),
                .duty(duty_r[g]),
                .clearReq(ctrl_r[g][CTRL_CLR_BIT]),
                .outLevel(genOut[g]),
                .irqPulse(genIrq[g]),
                .clearDone(genClrDone[g])
            );
        end
    endgenerate

    // ************************************************************
    // Read data mux
    // ************************************************************
    // Only control registers read back; the rest are write only
    always_comb begin
        readByte = 8'h00;
        for (int i = 0; i < NUM_GEN; i++) begin
            if (regIdx == IDX_CTRL[i]) begin
                readByte = ctrl_r[i];
                readByte[CTRL_OUT_BIT] = genOut[i];
            end
        end
    end

    // ************************************************************
    // APB answer
    // ************************************************************
    // One wait state: pready rises in the second access cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clkEn) begin
            pready <= accessPhase;
            // Unmapped words answer with an error and zero data
            pslverr <= accessPhase & ~addrValid;
            if (accessPhase && !pwrite) begin
                prdata <= {24'h00_0000, readByte};
            end else if (commit) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Pin routing
    // ************************************************************
    // Unrouted pins are released so the port can serve other functions
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : gen_pin
            localparam int GEN = p / PINS_PER_GEN;
            localparam int SLOT = p % PINS_PER_GEN;
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pinOut_r[p] <= 1'b0;
                    pinOe_r[p] <= 1'b0;
                end else if (clkEn) begin
                    pinOe_r[p] <= (ctrl_r[GEN][CTRL_PIN_MSB:CTRL_PIN_LSB] == PIN_CODE[SLOT]);
                    pinOut_r[p] <= genOut[GEN];
                end
            end
        end
    endgenerate

    // Interrupt pulses, one flop each
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= '0;
        end else if (clkEn) begin
            irq_r <= genIrq;
        end
    end

    // ************************************************************
    // Output ports
    // ************************************************************
    assign portBPin5Out = pinOut_r[0];
    assign portBPin5Oe = pinOe_r[0];
    assign portAPin0Out = pinOut_r[1];
    assign portAPin0Oe = pinOe_r[1];
    assign portBPin4Out = pinOut_r[2];
    assign portBPin4Oe = pinOe_r[2];
    assign portBPin6Out = pinOut_r[3];
    assign portBPin6Oe = pinOe_r[3];
    assign portAPin4Out = pinOut_r[4];
    assign portAPin4Oe = pinOe_r[4];
    assign portBPin7Out = pinOut_r[5];
    assign portBPin7Oe = pinOe_r[5];
    assign pwmGenAIrq = irq_r[0];
    assign pwmGenBIrq = irq_r[1];

endmodule // epwm_top

/* tb/epwm_chk.sv */
/*
 * Checker for the PWM register block: bus timing and pin routing.
 * Assumes clkEn held high, so bus answers are never frozen.
 */
`timescale 1ns/1ps
module epwm_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin enables
    input wire logic portBPin5Oe,
    input wire logic portAPin0Oe,
    input wire logic portBPin4Oe,
    input wire logic portBPin6Oe,
    input wire logic portAPin4Oe,
    input wire logic portBPin7Oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Index inside the register span of both generators
    wire logic mapped = (paddr[7:2] >= 6'h20) && (paddr[7:2] <= 6'h2B);
    wire logic waitCyc = psel && penable && !pready;
    a_ready_follows: assert property (waitCyc |=> pready)
        else $error("pready missing after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_unmapped: assert property (waitCyc && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (waitCyc && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data left on bus");
    a_route_a_one: assert property ($onehot0({portBPin5Oe, portAPin0Oe, portBPin4Oe}))
        else $error("generator A drives two pins");
    a_route_b_one: assert property ($onehot0({portBPin6Oe, portAPin4Oe, portBPin7Oe}))
        else $error("generator B drives two pins");
endmodule // epwm_chk

bind epwm_top epwm_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portBPin5Oe(portBPin5Oe), .portAPin0Oe(portAPin0Oe), .portBPin4Oe(portBPin4Oe),
    .portBPin6Oe(portBPin6Oe), .portAPin4Oe(portAPin4Oe), .portBPin7Oe(portBPin7Oe));

/* tb/epwm_top_bench.sv */
/*
 * Self-checking bench for the two PWM generators over APB.
 * Assumes one clock; the fast RC level is made here, synchronous to it.
 */
`timescale 1ns/1ps
module epwm_top_bench;
    import epwm_pkg::*;
    // ********************
    // Stimulus and results
    // ********************
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic internalFastRcClock = 1'b0;
    logic fastRun = 1'b0;
    logic [1:0] fastCnt = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irqA, irqB;
    logic [2:0] oeA, oeB, outA, outB;
    logic [31:0] rdData, hiCnt, irqCnt;
    logic rdErr;
    int err_count = 0;
    int comparisons = 0;
    logic [2:0] codes [4] = '{3'h1, 3'h3, 3'h4, 3'h2};
    logic [7:0] scl [4] = '{8'h00, 8'h21, 8'h40, 8'h60};
    int dv [4] = '{1, 8, 16, 64};
    always #12.5 ref_clk = ~ref_clk;
    // Fast RC rises once every four cycles while enabled
    always @(posedge ref_clk) begin
        fastCnt <= fastCnt + 2'h1;
        internalFastRcClock <= fastRun & fastCnt[1];
    end
    epwm_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .internalFastRcClock(internalFastRcClock),
        .portBPin5Out(outA[0]), .portBPin5Oe(oeA[0]), .portAPin0Out(outA[1]), .portAPin0Oe(oeA[1]),
        .portBPin4Out(outA[2]), .portBPin4Oe(oeA[2]), .portBPin6Out(outB[0]), .portBPin6Oe(oeB[0]),
        .portAPin4Out(outB[1]), .portAPin4Oe(oeB[1]), .portBPin7Out(outB[2]), .portBPin7Oe(oeB[2]),
        .pwmGenAIrq(irqA), .pwmGenBIrq(irqB));
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_count++;
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] msk);
        xfer(idx, 1'b0, 8'h00);
        chk({rdErr, rdData[30:0] & {23'h0, msk}}, {24'h0, exp});
    endtask
    // Skip one period and four cycles, then count high cycles and pulses over one more period
    task automatic measure(input int cyc);
        hiCnt = 0;
        irqCnt = 0;
        repeat (cyc + 4) @(posedge ref_clk);
        repeat (cyc) begin
            @(posedge ref_clk);
            hiCnt += {31'h0, outA[0]};
            irqCnt += {31'h0, irqA};
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #400us;
        err_count++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(IDX_CTRL[0], 8'h00, 8'hFF);
        rd(IDX_CTRL[1], 8'h00, 8'hFF);
        rd(IDX_SCALER[0], 8'h00, 8'hFF);
        xfer(6'h3F, 1'b1, 8'hFF);
        chk({31'h0, rdErr}, 32'h1);
        $display("reset test done");
        for (int g = 0; g < 2; g++) begin
            for (int i = 0; i < 4; i++) begin
                xfer(IDX_CTRL[g], 1'b1, {3'h1, 1'b0, codes[i], 1'b0});
                repeat (3) @(posedge ref_clk);
                chk({29'h0, g ? oeB : oeA}, i < 3 ? 32'h1 << i : 32'h0);
                chk({29'h0, (g ? outB : outA) & (g ? oeB : oeA)}, {29'h0, g ? oeB : oeA});
                rd(IDX_CTRL[g], {3'h3, 1'b0, codes[i], 1'b0}, 8'hFF);
            end
        end
        $display("routing test done");
        xfer(IDX_BOUND_HIGH[0], 1'b1, 8'h01);
        xfer(IDX_BOUND_LOW[0], 1'b1, 8'h40);
        xfer(IDX_DUTY_LOW[0], 1'b1, 8'h60);
        xfer(IDX_DUTY_HIGH[0], 1'b1, 8'h00);
        xfer(IDX_CTRL[0], 1'b1, 8'h82);
        for (int i = 0; i < 4; i++) begin
            xfer(IDX_SCALER[0], 1'b1, scl[i]);
            measure(11 * dv[i]);
            chk(hiCnt, 3 * dv[i]);
            chk(irqCnt, 32'h1);
        end
        xfer(IDX_SCALER[0], 1'b1, 8'h00);
        xfer(IDX_DUTY_LOW[0], 1'b1, 8'hE0);
        measure(11);
        chk(hiCnt, 32'd3);
        xfer(IDX_DUTY_HIGH[0], 1'b1, 8'h01);
        measure(11);
        chk({hiCnt[15:0], irqCnt[15:0]}, {16'd11, 16'd0});
        xfer(IDX_SCALER[0], 1'b1, 8'h80);
        measure(11);
        chk(irqCnt, 32'h1);
        xfer(IDX_CTRL[0], 1'b1, 8'h02);
        measure(11);
        chk({hiCnt[15:0], irqCnt[15:0]}, 32'h0);
        $display("counting test done");
        xfer(IDX_DUTY_LOW[0], 1'b1, 8'h60);
        xfer(IDX_DUTY_HIGH[0], 1'b1, 8'h00);
        fastRun <= 1'b1;
        xfer(IDX_CTRL[0], 1'b1, 8'h83);
        measure(44);
        chk(hiCnt, 32'd12);
        xfer(IDX_CTRL[0], 1'b1, 8'h93);
        rd(IDX_CTRL[0], 8'h83, 8'hBF);
        xfer(IDX_CTRL[1], 1'b1, 8'h91);
        rd(IDX_CTRL[1], 8'h81, 8'hBF);
        // Gen B at reset bound and duty: one match pulse per fast tick
        irqCnt = 0;
        repeat (44) begin
            @(posedge ref_clk);
            irqCnt += {31'h0, irqB};
        end
        chk(irqCnt, 32'd11);
        $display("clock and clear test done");
        test_done();
    end
endmodule // epwm_top_bench
